//--- verilog/nsi_pkg.sv
// Constants and types for the fieldbus node state indicator.
// Assumes a 10 MHz ref_clk and a synchronous active-low reset.
`default_nettype none
package nsi_pkg;
    localparam int CLK_HZ = 10000000;
    // Blink timing in milliseconds, as displayed.
    localparam int FLICKER_HALF_MS = 50;
    localparam int BLINK_HALF_MS = 200;
    localparam int FLASH_ON_MS = 200;
    localparam int FLASH_OFF_MS = 200;
    localparam int FLASH_PERIOD_MS = 1000;
    // Base tick of the flash divider.
    localparam int TICK_MS = 50;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int FLICKER_TICKS = FLICKER_HALF_MS / TICK_MS;
    localparam int BLINK_TICKS = BLINK_HALF_MS / TICK_MS;
    localparam int FLASH_ON_TICKS = FLASH_ON_MS / TICK_MS;
    localparam int FLASH_OFF_TICKS = FLASH_OFF_MS / TICK_MS;
    localparam int PERIOD_TICKS = FLASH_PERIOD_MS / TICK_MS;
    localparam int TIMEOUT_MS = 5000;
    localparam int TIMEOUT_CYCLES = CLK_HZ / 1000 * TIMEOUT_MS;
    localparam logic [4:0] PERIOD_LAST = 5'(PERIOD_TICKS - 1);
    localparam logic [4:0] ON_LEN = 5'(FLASH_ON_TICKS);
    localparam logic [4:0] SLOT_LEN = 5'(FLASH_ON_TICKS + FLASH_OFF_TICKS);
    localparam logic [4:0] FLICKER_LEN = 5'(FLICKER_TICKS);
    localparam logic [4:0] BLINK_LEN = 5'(BLINK_TICKS);
    localparam logic [1:0] PAT_OFF = 2'h0;
    localparam logic [1:0] PAT_ONE = 2'h1;
    localparam logic [1:0] PAT_TWO = 2'h2;
    localparam logic [1:0] PAT_THREE = 2'h3;
    typedef enum logic [2:0] {
        inactiveState,
        plainEthernetFallback,
        preopFirst,
        preopSecond,
        readyToRun,
        runningState,
        haltedState
    } node_state_t;
endpackage
`default_nettype wire

//--- verilog/flash_pattern.sv
// Flash pattern generator driving one LED from a base tick.
// Assumes tick is a one-cycle pulse on the same clock.
`default_nettype none
module flash_pattern
    import nsi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic tick,
    input wire logic [1:0] flashCount,
    output logic ledOn
);
    typedef struct packed {
        logic [4:0] phase;
        logic led;
    } flash_reg_t;
    flash_reg_t st, next_st;
    logic [4:0] slotPos;
    logic [4:0] slotIdx;

    always_comb begin
        next_st = st;
        slotIdx = 5'h00;
        slotPos = st.phase;
        if (st.phase >= SLOT_LEN) begin
            slotIdx = 5'h01;
            slotPos = st.phase - SLOT_LEN;
        end
        if (st.phase >= 5'(2 * SLOT_LEN)) begin
            slotIdx = 5'h02;
            slotPos = st.phase - 5'(2 * SLOT_LEN);
        end
        if (tick) begin
            next_st.phase = (st.phase == PERIOD_LAST) ? 5'h00
                : st.phase + 5'h01;
        end
        next_st.led = (slotIdx < {3'h0, flashCount}) && (slotPos < ON_LEN)
            && (st.phase < 5'(3 * SLOT_LEN));
        if (!nrst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    assign ledOn = st.led;
endmodule
`default_nettype wire

//--- verilog/node_state_indicator.sv
// Node state tracker and green/red status LED driver for a fieldbus port.
// Assumes event inputs arrive from a frame receiver on ref_clk.
`default_nettype none
module node_state_indicator
    import nsi_pkg::*;
#(
    parameter int TimeoutCycles = TIMEOUT_CYCLES,
    parameter int TickCycles = TICK_CYCLES
)
(
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic managingNodeRole,
    input wire logic nodeEnable,
    input wire logic frameSeen,
    input wire logic startOfCycle,
    input wire logic cmdReady,
    input wire logic cmdRun,
    input wire logic cmdHalt,
    input wire logic cmdPreop,
    input wire logic configDone,
    input wire logic managerFailed,
    output logic greenLed,
    output logic redLed,
    output logic ethernetMode,
    output logic realTimeCycle,
    output logic reducedCycle,
    output logic cyclicExchange,
    output logic asyncExchange,
    output logic evaluateInputs,
    output logic mappingActive,
    output logic configureNodes,
    output logic acceptConfig,
    output logic driveOutputs,
    output logic supplyInputs
);
    typedef struct packed {
        node_state_t state;
        logic role;
        logic roleValid;
        logic [31:0] waitCnt;
        logic [31:0] divCnt;
        logic tick;
        logic [4:0] blinkCnt;
        logic blinkLed;
        logic green;
        logic red;
        logic [10:0] outs;
    } nsi_reg_t;
    nsi_reg_t st, next_st;
    logic [1:0] flashCount;
    logic flashLed;
    logic [4:0] blinkLen;
    logic [10:0] next_outs;

    flash_pattern u_flash (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(st.tick),
        .flashCount(flashCount),
        .ledOn(flashLed)
    );

    always_comb begin
        flashCount = PAT_OFF;
        case (st.state)
            preopFirst: flashCount = PAT_ONE;
            preopSecond: flashCount = PAT_TWO;
            readyToRun: flashCount = PAT_THREE;
            default: flashCount = PAT_OFF;
        endcase
    end

    always_comb begin
        next_st = st;
        next_outs = 11'h000;
        blinkLen = (st.state == plainEthernetFallback) ? FLICKER_LEN
            : BLINK_LEN;
        // The role is latched once after reset, so a strap change mid-run
        // cannot move a running node between roles.
        if (!st.roleValid) begin
            next_st.role = managingNodeRole;
            next_st.roleValid = 1'b1;
        end
        next_st.tick = 1'b0;
        if (st.divCnt >= 32'(TickCycles - 1)) begin
            next_st.divCnt = 32'h0000_0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.divCnt = st.divCnt + 32'h0000_0001;
        end
        if (st.tick) begin
            if (st.blinkCnt >= blinkLen - 5'h01) begin
                next_st.blinkCnt = 5'h00;
                next_st.blinkLed = ~st.blinkLed;
            end else begin
                next_st.blinkCnt = st.blinkCnt + 5'h01;
            end
        end
        case (st.state)
            inactiveState: begin
                if (!nodeEnable || !st.roleValid) begin
                    next_st.waitCnt = 32'h0000_0000;
                end else if (st.role) begin
                    if (frameSeen) begin
                        next_st.waitCnt = 32'h0000_0000;
                    end else if (st.waitCnt >= 32'(TimeoutCycles - 1)) begin
                        next_st.state = preopFirst;
                    end else begin
                        next_st.waitCnt = st.waitCnt + 32'h0000_0001;
                    end
                end else begin
                    if (frameSeen) begin
                        next_st.state = preopFirst;
                    end else if (st.waitCnt >= 32'(TimeoutCycles - 1)) begin
                        next_st.state = plainEthernetFallback;
                    end else begin
                        next_st.waitCnt = st.waitCnt + 32'h0000_0001;
                    end
                end
            end
            plainEthernetFallback: begin
                if (!st.role && frameSeen) begin
                    next_st.state = preopFirst;
                end
            end
            preopFirst: begin
                if (!st.role && startOfCycle) begin
                    next_st.state = preopSecond;
                end else if (st.role && configDone) begin
                    next_st.state = preopSecond;
                end
            end
            preopSecond: begin
                if (!st.role && cmdReady) begin
                    next_st.state = readyToRun;
                end else if (st.role && configDone) begin
                    next_st.state = readyToRun;
                end
            end
            readyToRun: begin
                if (cmdRun || (st.role && configDone)) begin
                    next_st.state = runningState;
                end
            end
            runningState: begin
                // halt only on command, never as manager.
                if (!st.role && cmdHalt) begin
                    next_st.state = haltedState;
                end
            end
            haltedState: begin
                if (cmdPreop) begin
                    next_st.state = preopSecond;
                end
            end
            default: next_st.state = inactiveState;
        endcase
        case (st.state)
            plainEthernetFallback, haltedState: next_st.green = st.blinkLed;
            preopFirst, preopSecond, readyToRun: next_st.green = flashLed;
            runningState: next_st.green = 1'b1;
            default: next_st.green = 1'b0;
        endcase
        next_st.red = !st.role && managerFailed &&
            (st.state == preopFirst || st.state == preopSecond ||
             st.state == readyToRun);
        // Order: ether, rt, reduced, cyclic, async, eval, map, cfgNodes,
        // acceptCfg, drive, supply.
        case (st.state)
            plainEthernetFallback: next_outs = 11'h400;
            preopFirst: next_outs = st.role ? 11'h300 : 11'h204;
            preopSecond: next_outs = st.role ? 11'h2d8 : 11'h2c4;
            readyToRun: next_outs = st.role ? 11'h2c0 : 11'h2d2;
            runningState: next_outs = 11'h2fb;
            haltedState: next_outs = 11'h200;
            default: next_outs = 11'h000;
        endcase
        next_st.outs = next_outs;
        if (!nrst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge ref_clk) begin
        st <= next_st;
    end

    assign greenLed = st.green;
    assign redLed = st.red;
    assign ethernetMode = st.outs[10];
    assign realTimeCycle = st.outs[9];
    assign reducedCycle = st.outs[8];
    assign cyclicExchange = st.outs[7];
    assign asyncExchange = st.outs[6];
    assign evaluateInputs = st.outs[5];
    assign mappingActive = st.outs[4];
    assign configureNodes = st.outs[3];
    assign acceptConfig = st.outs[2];
    assign driveOutputs = st.outs[1];
    assign supplyInputs = st.outs[0];

    // Activity outputs lag the state by one edge, so output checks wait
    // until the state has been seen on two edges in a row.
    a_halt_no_manager: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        st.role |-> st.state != haltedState)
        else $error("Manager entered halted state.");
    a_fallback_sticky: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (st.role && st.state == plainEthernetFallback) |=>
        st.state == plainEthernetFallback)
        else $error("Manager left fallback without reset.");
    a_fallback_wakes: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (!st.role && st.state == plainEthernetFallback && frameSeen) |=>
        st.state == preopFirst)
        else $error("Controlled node missed wake traffic.");
    a_soc_advance: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (!st.role && st.state == preopFirst && startOfCycle) |=>
        st.state == preopSecond)
        else $error("Start of cycle ignored.");
    a_ready_cmd: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (!st.role && st.state == preopSecond && cmdReady) |=>
        st.state == readyToRun)
        else $error("Ready command ignored.");
    a_run_green: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        st.state == runningState [*2] |-> greenLed)
        else $error("Green not steady in running state.");
    a_inactive_dark: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        st.state == inactiveState [*2] |-> !greenLed)
        else $error("Green lit while inactive.");
    a_halted_nodata: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        $past(st.state) == haltedState && st.state == haltedState
        |-> !driveOutputs && !supplyInputs)
        else $error("Halted node moved data.");
    a_red_failure: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (!st.role && managerFailed && st.state == readyToRun) |=> redLed)
        else $error("Manager failure not shown.");
    a_fallback_plain: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        $past(st.state) == plainEthernetFallback
        && st.state == plainEthernetFallback
        |-> ethernetMode && !realTimeCycle)
        else $error("Fallback ran a real-time cycle.");
    a_manager_traffic_holds: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (st.role && st.state == inactiveState && frameSeen) |=>
        st.state == inactiveState)
        else $error("Manager started despite bus traffic.");
    a_manager_timeout_start: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (st.role && st.roleValid && nodeEnable && !frameSeen &&
        st.state == inactiveState && st.waitCnt >= 32'(TimeoutCycles - 1))
        |=> st.state == preopFirst)
        else $error("Manager missed its start timeout.");
    a_cn_traffic_start: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (!st.role && st.roleValid && nodeEnable && frameSeen &&
        st.state == inactiveState) |=> st.state == preopFirst)
        else $error("Controlled node ignored start traffic.");
    a_cn_timeout_fallback: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (!st.role && st.roleValid && nodeEnable && !frameSeen &&
        st.state == inactiveState && st.waitCnt >= 32'(TimeoutCycles - 1))
        |=> st.state == plainEthernetFallback)
        else $error("Controlled node missed fallback timeout.");
    a_reduced_cycle_only: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        st.role && $past(st.state) == preopFirst && st.state == preopFirst
        |-> reducedCycle && !cyclicExchange)
        else $error("Manager first preop not in reduced cycle.");
    a_cn_preop_accept: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !st.role && $past(st.state) == preopFirst && st.state == preopFirst
        |-> acceptConfig && realTimeCycle)
        else $error("Controlled first preop refuses configuration.");
    a_mgr_preop_config: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        st.role && $past(st.state) == preopSecond && st.state == preopSecond
        |-> cyclicExchange && configureNodes && !evaluateInputs)
        else $error("Manager second preop activity wrong.");
    a_cn_config_accept: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !st.role && $past(st.state) == preopSecond && st.state == preopSecond
        |-> acceptConfig)
        else $error("Controlled second preop refuses configuration.");
    a_mgr_ready_drop: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        st.role && $past(st.state) == readyToRun && st.state == readyToRun
        |-> cyclicExchange && asyncExchange && !evaluateInputs)
        else $error("Manager ready state activity wrong.");
    a_cn_ready_mapped: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        !st.role && $past(st.state) == readyToRun && st.state == readyToRun
        |-> mappingActive && driveOutputs && !evaluateInputs)
        else $error("Controlled ready state activity wrong.");
    a_run_data_active: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        st.state == runningState [*2] |-> mappingActive && evaluateInputs)
        else $error("Running state does not use its data.");
    a_halt_only_cmd: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (st.state == runningState && !cmdHalt) |=>
        st.state != haltedState)
        else $error("Halted without a halt command.");
    a_halt_leave_cmd: assert property (
        @(posedge ref_clk) disable iff (!nrst)
        (st.state == haltedState && !cmdPreop) |=>
        st.state == haltedState)
        else $error("Left halted without a command.");
    c_reach_run: cover property (@(posedge ref_clk) st.state == runningState);
    c_reach_halt: cover property (@(posedge ref_clk) st.state == haltedState);
    c_reach_fallback: cover property (@(posedge ref_clk)
        st.state == plainEthernetFallback);
    c_red_on: cover property (@(posedge ref_clk) redLed);
endmodule
`default_nettype wire

//--- verification/manager_peer_model.sv
// Behavioural managing-node peer that issues frames and commands.
// Assumes the bench calls its tasks; lines change at the falling edge.
`default_nettype none
module manager_peer_model (
    input wire logic ref_clk,
    output logic frameSeen,
    output logic startOfCycle,
    output logic cmdReady,
    output logic cmdRun,
    output logic cmdHalt,
    output logic cmdPreop,
    output logic configDone,
    output logic managerFailed
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [6:0] line = 7'h00;
    logic failLvl = 1'b0;
    assign {configDone, cmdPreop, cmdHalt, cmdRun} = line[6:3];
    assign {cmdReady, startOfCycle, frameSeen} = line[2:0];
    assign managerFailed = failLvl;
    // one-cycle events.
    // Pulses last one cycle so a held line cannot count as two events.
    task automatic send(input logic [2:0] k);
        @(negedge ref_clk);
        line = 7'h01 << (k - 3'h1);
        @(negedge ref_clk);
        line = 7'h00;
    endtask
    task automatic hold(input logic [6:0] v);
        @(negedge ref_clk);
        line = v;
    endtask
    task automatic fail(input logic v);
        @(negedge ref_clk);
        failLvl = v;
    endtask
endmodule
`default_nettype wire

//--- verification/fieldbus_node_state_indicator_tb_top.sv
// Self-checking bench for the node state indicator.
// Assumes short divider values; the peer model drives all event inputs.
`default_nettype none
module fieldbus_node_state_indicator_tb_top import nsi_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TO = 20;
    localparam int TK = 4;
    typedef struct packed {
        logic [1:0] rst;
        logic [2:0] ev;
        logic mf;
        logic [7:0] win;
        logic [7:0] grn;
        logic red;
        logic [10:0] mask;
        logic [10:0] val;
    } row_t;
    // Green windows span whole periods, so counts do not depend on phase.
    row_t rows [15] = '{
        '{2'h1, 3'h0, 1'b0, 8'h50, 8'h28, 1'b0, 11'h600, 11'h400},
        '{2'h0, 3'h1, 1'b0, 8'h50, 8'h10, 1'b0, 11'h004, 11'h004},
        '{2'h0, 3'h0, 1'b1, 8'h50, 8'h10, 1'b1, 11'h004, 11'h004},
        '{2'h0, 3'h2, 1'b1, 8'h50, 8'h20, 1'b1, 11'h604, 11'h204},
        '{2'h0, 3'h3, 1'b1, 8'h50, 8'h30, 1'b1, 11'h032, 11'h012},
        '{2'h0, 3'h4, 1'b0, 8'h50, 8'h50, 1'b0, 11'h030, 11'h030},
        '{2'h0, 3'h5, 1'b0, 8'h40, 8'h20, 1'b0, 11'h003, 11'h000},
        '{2'h0, 3'h1, 1'b0, 8'h40, 8'h20, 1'b0, 11'h003, 11'h000},
        '{2'h0, 3'h6, 1'b0, 8'h50, 8'h20, 1'b0, 11'h604, 11'h204},
        '{2'h1, 3'h1, 1'b0, 8'h50, 8'h10, 1'b0, 11'h604, 11'h204},
        '{2'h2, 3'h0, 1'b0, 8'h50, 8'h10, 1'b0, 11'h180, 11'h100},
        '{2'h0, 3'h7, 1'b0, 8'h50, 8'h20, 1'b0, 11'h0a8, 11'h088},
        '{2'h0, 3'h7, 1'b0, 8'h50, 8'h30, 1'b0, 11'h0e0, 11'h0c0},
        '{2'h0, 3'h7, 1'b0, 8'h50, 8'h50, 1'b0, 11'h030, 11'h030},
        '{2'h0, 3'h5, 1'b0, 8'h50, 8'h50, 1'b0, 11'h033, 11'h033}
    };
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic role = 1'b0;
    logic enable = 1'b0;
    int bad_count = 0;
    int check_count = 0;
    wire logic frameSeen, startOfCycle, cmdReady, cmdRun, cmdHalt;
    wire logic cmdPreop, configDone, managerFailed;
    logic greenLed, redLed, ethernetMode, realTimeCycle, reducedCycle;
    logic cyclicExchange, asyncExchange, evaluateInputs, mappingActive;
    logic configureNodes, acceptConfig, driveOutputs, supplyInputs;
    logic [10:0] act;
    assign act = {ethernetMode, realTimeCycle, reducedCycle,
        cyclicExchange, asyncExchange, evaluateInputs, mappingActive,
        configureNodes, acceptConfig, driveOutputs, supplyInputs};
    manager_peer_model peer_u (.ref_clk(ref_clk), .frameSeen(frameSeen),
        .startOfCycle(startOfCycle), .cmdReady(cmdReady), .cmdRun(cmdRun),
        .cmdHalt(cmdHalt), .cmdPreop(cmdPreop), .configDone(configDone),
        .managerFailed(managerFailed));
    node_state_indicator #(.TimeoutCycles(TO), .TickCycles(TK)) dut_u (
        .ref_clk(ref_clk), .nrst(nrst), .managingNodeRole(role),
        .nodeEnable(enable), .frameSeen(frameSeen),
        .startOfCycle(startOfCycle), .cmdReady(cmdReady), .cmdRun(cmdRun),
        .cmdHalt(cmdHalt), .cmdPreop(cmdPreop), .configDone(configDone),
        .managerFailed(managerFailed), .greenLed(greenLed), .redLed(redLed),
        .ethernetMode(ethernetMode), .realTimeCycle(realTimeCycle),
        .reducedCycle(reducedCycle), .cyclicExchange(cyclicExchange),
        .asyncExchange(asyncExchange), .evaluateInputs(evaluateInputs),
        .mappingActive(mappingActive), .configureNodes(configureNodes),
        .acceptConfig(acceptConfig), .driveOutputs(driveOutputs),
        .supplyInputs(supplyInputs));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic print_verdict();
        if (bad_count == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [10:0] exp,
            input logic [10:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic do_reset(input logic mgr, input logic en);
        @(negedge ref_clk);
        nrst = 1'b0;
        role = mgr;
        enable = en;
        repeat (5) @(negedge ref_clk);
        nrst = 1'b1;
        @(negedge ref_clk);
    endtask
    task automatic measure(input logic [7:0] win, output logic [7:0] n);
        n = 8'h00;
        repeat (win) begin
            @(negedge ref_clk);
            if (greenLed === 1'b1) n = n + 8'h01;
        end
    endtask
    // The run is cut short if a task never returns.
    initial begin
        #2000000;
        bad_count++;
        print_verdict();
    end
    initial begin
        logic [7:0] n;
        for (int i = 0; i < 15; i++) begin
            if (rows[i].rst != 2'h0) do_reset(rows[i].rst[1], 1'b1);
            peer_u.fail(rows[i].mf);
            if (rows[i].ev != 3'h0) peer_u.send(rows[i].ev);
            else if (rows[i].rst != 2'h0) repeat (TO + 8) @(negedge ref_clk);
            repeat (6) @(negedge ref_clk);
            measure(rows[i].win, n);
            chk("green", {3'h0, rows[i].grn}, {3'h0, n});
            chk("red", {10'h000, rows[i].red}, {10'h000, redLed});
            chk("activity", rows[i].val, act & rows[i].mask);
        end
        @(negedge ref_clk);
        nrst = 1'b0;
        repeat (3) @(negedge ref_clk);
        chk("reset act", 11'h000, act);
        chk("reset leds", 11'h000, {9'h000, greenLed, redLed});
        do_reset(1'b0, 1'b0);
        repeat (TO + 20) @(negedge ref_clk);
        measure(8'h50, n);
        chk("idle green", 11'h000, {3'h0, n});
        chk("idle act", 11'h000, act);
        do_reset(1'b1, 1'b1);
        peer_u.hold(7'h01);
        repeat (TO + 20) @(negedge ref_clk);
        measure(8'h50, n);
        chk("unstarted green", 11'h000, {3'h0, n});
        chk("unstarted act", 11'h000, act);
        peer_u.hold(7'h00);
        print_verdict();
    end
endmodule
`default_nettype wire
